//--- inc/qdl_pkg.sv
package qdl_pkg;
   // ---------------------------------------------------------------
   // Frame and code layout
   // ---------------------------------------------------------------
   localparam int          FRAME_BITS = 24;
   localparam int          CODE_W     = 16;
   localparam int          NUM_CH     = 4;
   localparam int          CNT_W      = 5;
   localparam int          DATA_LSB   = 0;
   localparam int          ADDR_LSB   = 16;
   localparam int          ADDR_W     = 4;
   localparam int          CMD_LSB    = 20;
   localparam int          CMD_W      = 4;
   localparam int          FIFO_DEPTH = 4;

   // Straight binary scale points
   localparam logic [15:0] CODE_ZERO  = 16'h0000;
   localparam logic [15:0] CODE_MID   = 16'h8000;

   // Command codes in the top nibble of a frame
   localparam logic [3:0]  CMD_WRITE  = 4'h1;
   localparam logic [3:0]  CMD_RDBACK = 4'h9;

   // Decode of one frame
   typedef enum {QDL_OP_NONE, QDL_OP_WRITE, QDL_OP_RDBACK} qdl_op_e;
endpackage : qdl_pkg

//--- logic/qdl_core.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Word FIFO, flip-flop storage
// ---------------------------------------------------------------
module qdl_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      fill_r;
   logic             push;
   logic             pop;

   // Honest full and empty from the fill count
   assign in_ready  = (fill_r != (AW+1)'(DEPTH));
   assign out_valid = (fill_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_r[rd_r];

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_r   <= '0;
         rd_r   <= '0;
         fill_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
         end
         fill_r <= fill_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : qdl_fifo

// Notes on behaviour
// - A frame starts when frame sync falls and takes data on the next 24 falling serial clock edges.
// - The serial input shift register is exactly 24 bits wide.
// - Serial input is sampled on each falling serial clock edge, so the host sets it up before.
// - Serial output changes on the rising serial clock edge and is captured on the next falling one.
// - Serial output carries shifted data onward for daisy chains and returns register contents on readback.
// - A low load pin copies every input register with new data into its DAC register, all at once.
// - The load pin works pulsed or held low permanently.
// - The reset pin acts independently of the serial clock and triggers on its falling edge.
// - While the reset pin is low, load requests are ignored and no transfer happens.
// - A reset pin event writes input and DAC registers with zero or midscale, by the select pin.
// - At power-on all four channels start at zero scale or midscale, by the select pin.
// - Channel codes are straight binary, all zeros zero scale and all ones full scale.
module qdl_core #(
   parameter int CH = qdl_pkg::NUM_CH
) (
   // System clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 rst,
   // Serial link
   input  wire logic                                 sclk,
   input  wire logic                                 frame_sync_n,
   input  wire logic                                 serial_in,
   output logic                                      serial_out,
   // Control pins
   input  wire logic                                 load_outputs_n,
   input  wire logic                                 reset_pin_n,
   input  wire logic                                 reset_level_select,
   // Converter side
   output logic [CH-1:0][qdl_pkg::CODE_W-1:0]        dac_code,
   output logic                                      dac_update,
   output logic                                      frame_dropped
);
   import qdl_pkg::*;

   // ---------------------------------------------------------------
   // Link domain: falling-edge shifter
   // ---------------------------------------------------------------
   logic [CNT_W-1:0]      bit_cnt_r;
   logic [FRAME_BITS-1:0] shift_r;
   logic [FRAME_BITS-1:0] hold_r;
   logic [FRAME_BITS-1:0] shift_src;
   logic                  done_tog_r;
   logic                  out_r;
   logic [FRAME_BITS-1:0] rb_word_r;
   logic                  rb_armed_r;

   // Readback word replaces the shifter only at a frame's first edge
   assign shift_src = (bit_cnt_r == '0 && rb_armed_r) ? rb_word_r : shift_r;

   // Frame sync high clears the count; sclk may stop between frames
   always_ff @(negedge sclk or posedge frame_sync_n) begin
      if (frame_sync_n) begin
         bit_cnt_r <= '0;
      end else if (bit_cnt_r != CNT_W'(FRAME_BITS)) begin
         bit_cnt_r <= bit_cnt_r + CNT_W'(1);
      end
   end

   // Sample the input bit, extra edges beyond the frame are ignored;
   // cleared by rst so the first word passed down a chain is defined
   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         shift_r <= '0;
      end else if (!frame_sync_n && bit_cnt_r != CNT_W'(FRAME_BITS)) begin
         shift_r <= {shift_src[FRAME_BITS-2:0], serial_in};
      end
   end

   // Full word held for the system side, flagged by a toggle
   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         done_tog_r <= 1'b0;
      end else if (!frame_sync_n && bit_cnt_r == CNT_W'(FRAME_BITS-1)) begin
         done_tog_r <= ~done_tog_r;
      end
   end

   always_ff @(negedge sclk) begin
      if (!frame_sync_n && bit_cnt_r == CNT_W'(FRAME_BITS-1)) begin
         hold_r <= {shift_r[FRAME_BITS-2:0], serial_in};
      end
   end

   // Output launched on the rising edge, one word behind the input
   always_ff @(posedge sclk) begin
      out_r <= shift_src[FRAME_BITS-1];
   end
   assign serial_out = out_r;

   // ---------------------------------------------------------------
   // System domain: synchronisers
   // ---------------------------------------------------------------
   logic [1:0] tog_s;
   logic       tog_seen_r;
   logic [1:0] sync_s;
   logic [1:0] load_s;
   logic [1:0] rpin_s;
   logic [1:0] sel_s;
   logic       rpin_prev_r;

   // Two flops per pin; first stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         tog_s  <= '0;
         sync_s <= 2'b11;
         load_s <= 2'b11;
         rpin_s <= 2'b11;
      end else begin
         tog_s  <= {tog_s[0], done_tog_r};
         sync_s <= {sync_s[0], frame_sync_n};
         load_s <= {load_s[0], load_outputs_n};
         rpin_s <= {rpin_s[0], reset_pin_n};
      end
   end

   // Strap is sampled free-running so it is valid while rst is held
   always_ff @(posedge clk) begin
      sel_s <= {sel_s[0], reset_level_select};
   end

   // ---------------------------------------------------------------
   // Frame commit into the FIFO
   // ---------------------------------------------------------------
   logic                  frame_pend_r;
   logic [FRAME_BITS-1:0] word_r;
   logic                  push;
   logic                  fifo_in_ready;
   logic                  fifo_out_valid;
   logic                  fifo_out_ready;
   logic [FRAME_BITS-1:0] fifo_out_data;
   logic                  sync_hi;
   logic                  new_frame;
   logic                  drop_r;

   assign sync_hi   = sync_s[1];
   assign new_frame = (tog_s[1] != tog_seen_r);
   // Commit waits for frame sync high; a short frame never toggles
   assign push      = frame_pend_r && sync_hi;

   // Hold word is stable here: next write needs 24 more sclk edges
   always_ff @(posedge clk) begin
      if (rst) begin
         tog_seen_r   <= 1'b0;
         frame_pend_r <= 1'b0;
         drop_r       <= 1'b0;
      end else begin
         tog_seen_r <= tog_s[1];
         drop_r     <= push && !fifo_in_ready;
         if (new_frame) begin
            frame_pend_r <= 1'b1;
         end else if (push) begin
            frame_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (new_frame) begin
         word_r <= hold_r;
      end
   end
   assign frame_dropped = drop_r;

   qdl_fifo #(
      .WIDTH (FRAME_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (word_r),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ---------------------------------------------------------------
   // Channel registers
   // ---------------------------------------------------------------
   logic [CH-1:0][CODE_W-1:0] inp_r;
   logic [CH-1:0][CODE_W-1:0] dac_r;
   logic [CH-1:0]             pend_r;
   logic                      upd_r;
   logic                      load_now;
   logic                      rpin_fell;
   logic                      pop;
   qdl_op_e                   op;
   logic [ADDR_W-1:0]         mask;
   logic [CODE_W-1:0]         rst_code;

   function automatic qdl_op_e decode_op(input logic [FRAME_BITS-1:0] w);
      case (w[CMD_LSB +: CMD_W])
         CMD_WRITE:  decode_op = QDL_OP_WRITE;
         CMD_RDBACK: decode_op = QDL_OP_RDBACK;
         default:    decode_op = QDL_OP_NONE;
      endcase
   endfunction : decode_op

   // Straight binary: midscale is the top bit alone
   assign rst_code  = sel_s[1] ? CODE_MID : CODE_ZERO;
   assign rpin_fell = rpin_prev_r && !rpin_s[1];
   // Level test covers both a pulse and a pin tied low
   assign load_now  = !load_s[1] && rpin_s[1] && (pend_r != '0);
   // Drain stalls on a load and while a frame is on the wire
   assign fifo_out_ready = !load_now && sync_hi && !rpin_fell;
   assign pop       = fifo_out_valid && fifo_out_ready;
   assign op        = decode_op(fifo_out_data);
   assign mask      = fifo_out_data[ADDR_LSB +: ADDR_W];

   always_ff @(posedge clk) begin
      if (rst) begin
         rpin_prev_r <= 1'b1;
      end else begin
         rpin_prev_r <= rpin_s[1];
      end
   end

   // One block per channel for input, DAC and pending state
   genvar gi;
   generate
      for (gi = 0; gi < CH; gi++) begin : g_ch
         always_ff @(posedge clk) begin
            if (rst) begin
               inp_r[gi]  <= rst_code;
               dac_r[gi]  <= rst_code;
               pend_r[gi] <= 1'b0;
            end else if (rpin_fell) begin
               inp_r[gi]  <= rst_code;
               dac_r[gi]  <= rst_code;
               pend_r[gi] <= 1'b0;
            end else if (load_now) begin
               if (pend_r[gi]) begin
                  dac_r[gi] <= inp_r[gi];
               end
               pend_r[gi] <= 1'b0;
            end else if (pop && op == QDL_OP_WRITE && mask[gi]) begin
               inp_r[gi]  <= fifo_out_data[DATA_LSB +: CODE_W];
               pend_r[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   // Single strobe marks the simultaneous update
   always_ff @(posedge clk) begin
      if (rst) begin
         upd_r <= 1'b0;
      end else begin
         upd_r <= load_now;
      end
   end
   assign dac_code   = dac_r;
   assign dac_update = upd_r;

   // ---------------------------------------------------------------
   // Readback word for the next frame
   // ---------------------------------------------------------------
   // Changed only while frame sync is high, read by the link only
   // while it is low, so the word is stable wherever it is used.
   logic [1:0] rb_ch;
   always_comb begin
      rb_ch = '0;
      for (int i = CH-1; i >= 0; i--) begin
         if (mask[i]) begin
            rb_ch = 2'(i);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rb_armed_r <= 1'b0;
         rb_word_r  <= '0;
      end else if (pop && op == QDL_OP_RDBACK) begin
         rb_armed_r <= 1'b1;
         rb_word_r  <= {fifo_out_data[FRAME_BITS-1:CODE_W], inp_r[rb_ch]};
      end else if (pop) begin
         rb_armed_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_frame_count: assert property (@(negedge sclk) disable iff (frame_sync_n)
      bit_cnt_r == CNT_W'(FRAME_BITS) |=> bit_cnt_r == CNT_W'(FRAME_BITS))
      else $error("bit count moved past the frame end");

   a_shift_sample: assert property (@(negedge sclk) disable iff (frame_sync_n)
      bit_cnt_r < CNT_W'(FRAME_BITS) |=> shift_r[0] == $past(serial_in))
      else $error("serial input not sampled on falling edge");

   a_out_follow: assert property (@(posedge sclk) disable iff (frame_sync_n)
      bit_cnt_r != '0 |-> ##1 serial_out == $past(shift_r[FRAME_BITS-1]))
      else $error("serial output does not follow shifter");

   a_load_update: assert property (@(posedge clk) disable iff (rst)
      load_now |=> dac_update && pend_r == '0 ##1 !dac_update || load_now)
      else $error("load did not update all pending channels");

   a_reset_blocks: assert property (@(posedge clk) disable iff (rst)
      !rpin_s[1] && !rpin_fell |=> $stable(dac_r) && !dac_update)
      else $error("transfer while reset pin low");

   a_reset_codes: assert property (@(posedge clk) disable iff (rst)
      rpin_fell |=> dac_r[0] == $past(rst_code) && inp_r[CH-1] == $past(rst_code) && pend_r == '0)
      else $error("reset pin did not load scale code");

   a_por_codes: assert property (@(posedge clk)
      $fell(rst) |-> dac_r[0] == (sel_s[1] ? CODE_MID : CODE_ZERO))
      else $error("power-on code wrong");

   a_commit_wait: assert property (@(posedge clk) disable iff (rst)
      push |-> sync_hi && frame_pend_r && !$past(push))
      else $error("frame committed while sync low");

   c_write: cover property (@(posedge clk) pop && op == QDL_OP_WRITE);
   c_load: cover property (@(posedge clk) load_now ##1 dac_update);
   c_readback: cover property (@(posedge clk) pop && op == QDL_OP_RDBACK);
   c_drop: cover property (@(posedge clk) drop_r);
endmodule : qdl_core

//--- tb/qdl_host.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Host side of the serial link
// ---------------------------------------------------------------
module qdl_host (
   // Link outputs
   output logic      sclk,
   output logic      frame_sync_n,
   output logic      serial_in,
   // Link input
   input  wire logic serial_out
);
   localparam realtime HALF = 80.0;

   // Clock idles high and stands still between frames
   initial begin
      sclk         = 1'b1;
      frame_sync_n = 1'b1;
      serial_in    = 1'b0;
   end

   // One frame of nbits, MSB first; rx gathers serial_out on the falls
   // A long hold keeps sync low after the last edge, for a slow host
   task automatic send(input logic [23:0] word, input int nbits, input int hold_ns,
                       output logic [23:0] rx);
      rx           = '0;
      frame_sync_n = 1'b0;
      #(HALF);
      for (int i = 23; i > 23 - nbits; i--) begin
         serial_in = (i >= 0) ? word[i] : 1'b1; // Set up well ahead of the fall
         #(HALF);
         sclk  = 1'b0;
         if (i >= 0) rx[i] = serial_out;       // Captured on the fall
         #(HALF);
         sclk = 1'b1;
      end
      #(hold_ns);
      frame_sync_n = 1'b1;
      serial_in    = ~serial_in;               // Released line shows no stale bit
      #(HALF);                                 // Sync high gap far above 8 clk
   endtask : send
endmodule : qdl_host

//--- tb/tb.sv
`timescale 1ns/1ps

module tb;
   import qdl_pkg::*;

   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic                          clk                = 1'b0;
   logic                          rst                = 1'b1;
   logic                          load_outputs_n     = 1'b1;
   logic                          reset_pin_n        = 1'b1;
   logic                          reset_level_select = 1'b0;
   logic                          sclk;
   logic                          frame_sync_n;
   logic                          serial_in;
   logic                          serial_out;
   logic [NUM_CH-1:0][CODE_W-1:0] dac_code;
   logic                          dac_update;
   logic                          frame_dropped;
   logic [CODE_W-1:0]             exp_code [NUM_CH];
   logic [23:0]                   rx;
   int                            err_count  = 0;
   int                            num_checks = 0;

   qdl_core #(.CH(NUM_CH)) i_qdl_core (
      .clk(clk), .rst(rst), .sclk(sclk), .frame_sync_n(frame_sync_n), .serial_in(serial_in),
      .serial_out(serial_out), .load_outputs_n(load_outputs_n), .reset_pin_n(reset_pin_n),
      .reset_level_select(reset_level_select), .dac_code(dac_code), .dac_update(dac_update),
      .frame_dropped(frame_dropped));

   qdl_host i_qdl_host (.sclk(sclk), .frame_sync_n(frame_sync_n), .serial_in(serial_in),
      .serial_out(serial_out));

   // 250 MHz system clock
   always #2 clk = ~clk;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_clk

   task automatic check_all();
      for (int i = 0; i < NUM_CH; i++)
         check({8'h00, dac_code[i]}, {8'h00, exp_code[i]}, "channel code");
   endtask : check_all

   // Low pulse on the load pin; want says whether a transfer is due
   task automatic load_pulse(input logic want);
      logic seen;
      seen = 1'b0;
      @(posedge clk);
      load_outputs_n <= 1'b0;
      repeat (12) begin
         @(posedge clk);
         #1;
         if (dac_update === 1'b1) seen = 1'b1;
      end
      @(posedge clk);
      load_outputs_n <= 1'b1;
      check({23'h0, seen}, {23'h0, want}, "update pulse");
      check_all();
   endtask : load_pulse

   task automatic frame(input logic [23:0] w);
      i_qdl_host.send(w, 24, 0, rx);
      wait_clk(20);                            // Commit takes a handful of clk after sync rises
   endtask : frame

   // No frame may be lost at this pace
   always @(posedge clk)
      if (frame_dropped === 1'b1) check(24'h1, 24'h0, "frame dropped");

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_power_on();
      for (int i = 0; i < NUM_CH; i++) exp_code[i] = CODE_ZERO;
      check_all();
      @(posedge clk);
      reset_level_select <= 1'b1;
      rst                <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wait_clk(1);
      for (int i = 0; i < NUM_CH; i++) exp_code[i] = CODE_MID;
      check_all();
   endtask : t_power_on

   task automatic t_write_load();
      frame({CMD_WRITE, 4'b0101, 16'hffff});
      check_all();
      exp_code[0] = 16'hffff;
      exp_code[2] = 16'hffff;
      load_pulse(1'b1);
   endtask : t_write_load

   task automatic t_partial();
      i_qdl_host.send({CMD_WRITE, 4'b1111, 16'h1111}, 23, 0, rx);
      wait_clk(20);
      load_pulse(1'b0);
   endtask : t_partial

   task automatic t_daisy();
      frame(24'h005a3c);
      frame(24'h0c33aa);
      check(rx, 24'h005a3c, "daisy chain word");
   endtask : t_daisy

   task automatic t_readback();
      frame({CMD_WRITE, 4'b0010, 16'h1234});
      frame({CMD_RDBACK, 4'b0010, 16'h0000});
      frame(24'h000000);
      check(rx, {CMD_RDBACK, 4'b0010, 16'h1234}, "readback word");
   endtask : t_readback

   // Load pin held low: a write moves through once frame sync rises, not while sync is low
   task automatic t_tied_low();
      @(posedge clk);
      load_outputs_n <= 1'b0;
      wait_clk(10);
      exp_code[1] = 16'h1234;
      check_all();
      fork
         i_qdl_host.send({CMD_WRITE, 4'b1000, 16'h0001}, 24, 400, rx);
         begin
            repeat (24) @(negedge sclk);
            wait_clk(80);
            check_all();
         end
      join
      wait_clk(12);
      exp_code[3] = 16'h0001;
      check_all();
      @(posedge clk);
      load_outputs_n <= 1'b1;
   endtask : t_tied_low

   task automatic t_reset_pin();
      @(posedge clk);
      reset_level_select <= 1'b0;
      wait_clk(5);
      @(posedge clk);
      reset_pin_n <= 1'b0;
      wait_clk(10);
      for (int i = 0; i < NUM_CH; i++) exp_code[i] = CODE_ZERO;
      check_all();
      frame({CMD_WRITE, 4'b0100, 16'habcd});
      load_pulse(1'b0);
      frame({CMD_RDBACK, 4'b0001, 16'h0000});
      frame(24'h000000);
      check(rx, {CMD_RDBACK, 4'b0001, CODE_ZERO}, "input reg reset");
      @(posedge clk);
      reset_pin_n <= 1'b1;
      wait_clk(5);
      exp_code[2] = 16'habcd;
      load_pulse(1'b1);
   endtask : t_reset_pin

   // Two edges too many: the extra filler bits must not reach the word
   task automatic t_overrun();
      i_qdl_host.send({CMD_WRITE, 4'b0001, 16'h00c3}, 26, 0, rx);
      wait_clk(20);
      exp_code[0] = 16'h00c3;
      load_pulse(1'b1);
   endtask : t_overrun

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wait_clk(1);
      t_power_on();
      t_write_load();
      t_partial();
      t_daisy();
      t_readback();
      t_tied_low();
      t_reset_pin();
      t_overrun();
      complete_run();
   end

   // Watchdog: the scenarios need well under 100 us
   initial begin
      #300000;
      err_count++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end
endmodule : tb
